// ### verilog/tae_pkg.sv
// package: constants and carriers for the alarm, event and mask block
package tae_pkg;
	// register indices; byte address is four times the index
	localparam logic [7:0] IDX_INFO     = 8'h14;
	localparam logic [7:0] IDX_SR1      = 8'h16;
	localparam logic [7:0] IDX_IMR1     = 8'h17;
	localparam logic [7:0] IDX_SR2      = 8'h18;
	localparam logic [7:0] IDX_IMR2     = 8'h19;
	localparam logic [7:0] IDX_SR3      = 8'h1a;
	localparam logic [7:0] IDX_IMR3     = 8'h1b;
	localparam logic [7:0] IDX_SR4      = 8'h1c;
	localparam logic [7:0] IDX_IMR4     = 8'h1d;
	localparam logic [7:0] ADDR_INFO    = IDX_INFO << 2;
	localparam logic [7:0] ADDR_SR1     = IDX_SR1 << 2;
	localparam logic [7:0] ADDR_IMR1    = IDX_IMR1 << 2;
	localparam logic [7:0] ADDR_SR2     = IDX_SR2 << 2;
	localparam logic [7:0] ADDR_IMR2    = IDX_IMR2 << 2;
	localparam logic [7:0] ADDR_SR3     = IDX_SR3 << 2;
	localparam logic [7:0] ADDR_IMR3    = IDX_IMR3 << 2;
	localparam logic [7:0] ADDR_SR4     = IDX_SR4 << 2;
	localparam logic [7:0] ADDR_IMR4    = IDX_IMR4 << 2;
	localparam logic [7:0] REG_RESET    = 8'h00;

	// zero-run thresholds for framer carrier loss
	localparam logic [11:0] ZRUN_T1     = 12'h0c0;
	localparam logic [11:0] ZRUN_E1     = 12'h0ff;
	localparam logic [11:0] ZRUN_E1_EXT = 12'h800;

	// clock-loss timing: one channel time (8 bit periods)
	localparam int SYS_CLK_PERIOD_NS    = 25;
	localparam int T1_CHANNEL_NS        = 5181;
	localparam int E1_CHANNEL_NS        = 3906;
	localparam logic [8:0] T1_CHAN_CYC  =
		9'((T1_CHANNEL_NS + SYS_CLK_PERIOD_NS - 1) / SYS_CLK_PERIOD_NS);
	localparam logic [8:0] E1_CHAN_CYC  =
		9'((E1_CHANNEL_NS + SYS_CLK_PERIOD_NS - 1) / SYS_CLK_PERIOD_NS);

	// time slot 16 checks
	localparam int         TS16_DMA_BIT = 2;
	localparam logic [3:0] MF_LAST      = 4'hf;
	localparam logic [1:0] DMA_COUNT    = 2'h2;
	localparam logic [1:0] SAO_ZEROS    = 2'h3;

	// levels and pulses from the line interface and framer
	typedef struct packed {
		logic jitter_limit_trip;
		logic line_carrier_loss;
		logic tx_current_limit;
		logic tx_open_circuit;
		logic line_tx_clock_loss;
		logic yellow_alarm;
		logic unframed_all_ones;
		logic sync_lost;
		logic spare_code_seen;
		logic loop_down_seen;
		logic loop_up_seen;
		logic link_id_seen;
		logic remote_alarm;
		logic ais_ci_seen;
		logic tx_multiframe_tick;
		logic tx_align_frame_tick;
		logic rx_multiframe_tick;
		logic rx_crc4_mf_tick;
		logic rx_align_frame_tick;
	} tae_fr_t;

	// time slot 16 byte, one per frame
	typedef struct packed {
		logic       valid;
		logic       frame0;
		logic [7:0] data;
	} tae_ts16_t;
endpackage

// ### verilog/tae_alarm_event_status.sv
// alarm detectors, latched status, masks and interrupt summary of one transceiver
// Summary of operation
// - mask1 bit4 gates trip event; bits3..0 interrupt on both edges of line conditions.
// - T1 only, yellow-cleared event sets when yellow alarm goes away.
// - all-ones-cleared event sets when unframed all-ones goes away.
// - carrier-loss-cleared event sets when framer carrier loss goes away.
// - sync-regained event sets on sync, held until status read.
// - T1 only, yellow condition bit follows received yellow alarm.
// - unframed all-ones condition bit follows received all-ones code.
// - carrier loss after 192 zeros T1, 255 or 2048 zeros E1.
// - loss-of-sync bit set while not synchronized.
// - mask2 enables; condition bits interrupt on rising edge only, events plain.
// - T1 only, spare, loop-down, loop-up code conditions, both-edge interrupts.
// - tx clock loss after one channel time idle; optional output pin.
// - rx clock loss after one channel time without transition.
// - E1 only, link identification condition bit.
// - E1 distant multiframe alarm after two multiframes with ts16 bit set.
// - E1 only, remote alarm condition bit.
// - mask3 enables both-edge interrupts of each matching condition.
// - T1 only, AIS-CI event latched.
// - E1 signaling all-ones event when ts16 has under three zeros per 16 frames.
// - E1 signaling all-zeros event when ts16 all zeros over a multiframe.
// - transmit and receive multiframe events latched on framer boundaries.
// - E1 align-frame and CRC4 multiframe events latched on framer ticks.
// - info register bit per status register shows an enabled active interrupt.
//
// Added by the designer: the plain strobed port.
`timescale 1ns/1ps
module tae_alarm_event_status (
	input  wire logic              i_sys_clk,
	input  wire logic              i_rst,
	input  wire logic [7:0]        i_addr,
	input  wire logic [7:0]        i_wdata,
	input  wire logic              i_wr,
	input  wire logic              i_rd,
	output logic      [7:0]        o_rdata,
	input  wire logic              i_e1_mode,
	input  wire logic              i_extended_zero_count_sel,
	input  wire logic              i_clock_loss_pin_enable,
	input  wire logic              i_rx_pos_data_in,
	input  wire logic              i_rx_neg_data_in,
	input  wire logic              i_rx_clock_in,
	input  wire logic              i_tx_clock_in,
	input  wire tae_pkg::tae_fr_t   i_framer,
	input  wire tae_pkg::tae_ts16_t i_ts16,
	output logic                   o_tx_clock_loss,
	output logic                   o_irq
);
	// pin synchronisers: pos, neg, rx clock, tx clock
	logic [3:0]  sync1_ff;
	logic [3:0]  sync2_ff;
	logic        rxclk_d_ff;
	logic [11:0] zrun_ff;
	logic        fcl_ff;
	logic [11:0] zrun_lim;
	logic [8:0]  chan_lim;
	logic [1:0]  clk_now;
	logic [1:0]  clk_d_ff;
	logic [8:0]  idle_ff [2];
	logic [1:0]  clk_loss_ff;
	logic [1:0]  dma_cnt_ff;
	logic [3:0]  frm_ff;
	logic [1:0]  zeros_ff;
	logic        any_one_ff;
	logic        sao_evt;
	logic        saz_evt;
	logic [1:0]  nxt_zeros;
	logic        nxt_any_one;
	logic [3:0]  c1;
	logic [3:0]  c2;
	logic [7:0]  c3;
	logic [3:0]  p1_ff;
	logic [3:0]  p2_ff;
	logic [7:0]  p3_ff;
	logic [4:0]  l1_ff;
	logic [7:0]  l2_ff;
	logic [7:0]  l3_ff;
	logic [7:0]  l4_ff;
	logic [4:0]  set1;
	logic [7:0]  set2;
	logic [7:0]  set3;
	logic [7:0]  set4;
	logic [7:0]  imr1_ff;
	logic [7:0]  imr2_ff;
	logic [7:0]  imr3_ff;
	logic [7:0]  imr4_ff;
	logic [7:0]  sr1_v;
	logic [7:0]  sr2_v;
	logic [7:0]  sr3_v;
	logic [7:0]  sr4_v;
	logic [3:0]  info;
	logic [7:0]  nxt_rdata;
	logic        rd1;
	logic        rd2;
	logic        rd3;
	logic        rd4;

	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			sync1_ff <= 4'h0;
			sync2_ff <= 4'h0;
		end else begin
			sync1_ff <= {i_tx_clock_in, i_rx_clock_in, i_rx_neg_data_in, i_rx_pos_data_in};
			sync2_ff <= sync1_ff;
		end
	end

	// zero-run counter on rx clock rising edges
	always_comb begin
		if (!i_e1_mode) begin
			zrun_lim = tae_pkg::ZRUN_T1;
		end else if (i_extended_zero_count_sel) begin
			zrun_lim = tae_pkg::ZRUN_E1_EXT;
		end else begin
			zrun_lim = tae_pkg::ZRUN_E1;
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			rxclk_d_ff <= 1'b0;
			zrun_ff    <= 12'h000;
			fcl_ff     <= 1'b0;
		end else begin
			rxclk_d_ff <= sync2_ff[2];
			if (sync2_ff[2] && !rxclk_d_ff) begin
				if (sync2_ff[0] || sync2_ff[1]) begin
					zrun_ff <= 12'h000;
					fcl_ff  <= 1'b0;
				end else begin
					if (zrun_ff != zrun_lim) begin
						zrun_ff <= zrun_ff + 12'h001;
					end
					fcl_ff <= (zrun_ff + 12'h001) >= zrun_lim;
				end
			end
		end
	end

	// idle counters on the two clock pins: index 0 rx, 1 tx
	assign chan_lim = i_e1_mode ? tae_pkg::E1_CHAN_CYC : tae_pkg::T1_CHAN_CYC;
	assign clk_now  = sync2_ff[3:2];

	for (genvar g = 0; g < 2; g++) begin : g_clk_loss
		always_ff @(posedge i_sys_clk) begin
			if (i_rst) begin
				clk_d_ff[g]    <= 1'b0;
				idle_ff[g]     <= 9'h000;
				clk_loss_ff[g] <= 1'b0;
			end else begin
				clk_d_ff[g] <= clk_now[g];
				if (clk_now[g] != clk_d_ff[g]) begin
					idle_ff[g]     <= 9'h000;
					clk_loss_ff[g] <= 1'b0;
				end else if (idle_ff[g] != chan_lim) begin
					idle_ff[g] <= idle_ff[g] + 9'h001;
				end else begin
					clk_loss_ff[g] <= 1'b1;
				end
			end
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			o_tx_clock_loss <= 1'b0;
		end else begin
			o_tx_clock_loss <= i_clock_loss_pin_enable && clk_loss_ff[1];
		end
	end

	// time slot 16: distant multiframe alarm
	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			dma_cnt_ff <= 2'h0;
		end else if (i_ts16.valid && i_ts16.frame0) begin
			if (!i_ts16.data[tae_pkg::TS16_DMA_BIT]) begin
				dma_cnt_ff <= 2'h0;
			end else if (dma_cnt_ff != tae_pkg::DMA_COUNT) begin
				dma_cnt_ff <= dma_cnt_ff + 2'h1;
			end
		end
	end

	// time slot 16: zero count over a 16-frame multiframe
	function automatic logic [1:0] zsat(input logic [1:0] acc, input logic [7:0] b);
		logic [1:0] r;
		r = acc;
		for (int i = 0; i < 8; i++) begin
			if (!b[i] && r != tae_pkg::SAO_ZEROS) begin
				r = r + 2'h1;
			end
		end
		return r;
	endfunction

	always_comb begin
		nxt_zeros   = zsat(i_ts16.frame0 ? 2'h0 : zeros_ff, i_ts16.data);
		nxt_any_one = (i_ts16.frame0 ? 1'b0 : any_one_ff) || (|i_ts16.data);
	end

	assign sao_evt = i_e1_mode && i_ts16.valid && (frm_ff == tae_pkg::MF_LAST)
		&& !i_ts16.frame0 && (nxt_zeros != tae_pkg::SAO_ZEROS);
	assign saz_evt = i_e1_mode && i_ts16.valid && (frm_ff == tae_pkg::MF_LAST)
		&& !i_ts16.frame0 && !nxt_any_one;

	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			frm_ff     <= 4'h0;
			zeros_ff   <= 2'h0;
			any_one_ff <= 1'b0;
		end else if (i_ts16.valid) begin
			frm_ff     <= i_ts16.frame0 ? 4'h1 : frm_ff + 4'h1;
			zeros_ff   <= nxt_zeros;
			any_one_ff <= nxt_any_one;
		end
	end

	// live conditions
	assign c1 = {i_framer.line_carrier_loss, i_framer.tx_current_limit,
		i_framer.tx_open_circuit, i_framer.line_tx_clock_loss};
	assign c2 = {i_framer.yellow_alarm && !i_e1_mode,
		i_framer.unframed_all_ones,
		fcl_ff,
		i_framer.sync_lost};
	assign c3 = {i_framer.spare_code_seen && !i_e1_mode,
		i_framer.loop_down_seen && !i_e1_mode,
		i_framer.loop_up_seen && !i_e1_mode,
		clk_loss_ff[1],
		clk_loss_ff[0],
		i_framer.link_id_seen && i_e1_mode,
		(dma_cnt_ff == tae_pkg::DMA_COUNT) && i_e1_mode,
		i_framer.remote_alarm && i_e1_mode};

	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			p1_ff <= 4'h0;
			p2_ff <= 4'h0;
			p3_ff <= 8'h00;
		end else begin
			p1_ff <= c1;
			p2_ff <= c2;
			p3_ff <= c3;
		end
	end

	// latch set terms
	assign set1 = {i_framer.jitter_limit_trip, c1 ^ p1_ff};
	assign set2 = {!c2[3] && p2_ff[3],
		!c2[2] && p2_ff[2],
		!c2[1] && p2_ff[1],
		!c2[0] && p2_ff[0],
		c2 & ~p2_ff};
	assign set3 = c3 ^ p3_ff;
	assign set4 = {i_framer.ais_ci_seen && !i_e1_mode,
		sao_evt, saz_evt,
		i_framer.tx_multiframe_tick,
		i_framer.tx_align_frame_tick && i_e1_mode,
		i_framer.rx_multiframe_tick,
		i_framer.rx_crc4_mf_tick && i_e1_mode,
		i_framer.rx_align_frame_tick && i_e1_mode};

	assign rd1 = i_rd && (i_addr == tae_pkg::ADDR_SR1);
	assign rd2 = i_rd && (i_addr == tae_pkg::ADDR_SR2);
	assign rd3 = i_rd && (i_addr == tae_pkg::ADDR_SR3);
	assign rd4 = i_rd && (i_addr == tae_pkg::ADDR_SR4);

	// latches: read clears, a new event in the same cycle wins
	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			l1_ff <= 5'h00;
			l2_ff <= tae_pkg::REG_RESET;
			l3_ff <= tae_pkg::REG_RESET;
			l4_ff <= tae_pkg::REG_RESET;
		end else begin
			l1_ff <= (rd1 ? 5'h00 : l1_ff) | set1;
			l2_ff <= (rd2 ? 8'h00 : l2_ff) | set2;
			l3_ff <= (rd3 ? 8'h00 : l3_ff) | set3;
			l4_ff <= (rd4 ? 8'h00 : l4_ff) | set4;
		end
	end

	// mask registers
	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			imr1_ff <= tae_pkg::REG_RESET;
			imr2_ff <= tae_pkg::REG_RESET;
			imr3_ff <= tae_pkg::REG_RESET;
			imr4_ff <= tae_pkg::REG_RESET;
		end else if (i_wr) begin
			if (i_addr == tae_pkg::ADDR_IMR1) begin
				imr1_ff <= i_wdata;
			end else if (i_addr == tae_pkg::ADDR_IMR2) begin
				imr2_ff <= i_wdata;
			end else if (i_addr == tae_pkg::ADDR_IMR3) begin
				imr3_ff <= i_wdata;
			end else if (i_addr == tae_pkg::ADDR_IMR4) begin
				imr4_ff <= i_wdata;
			end
		end
	end

	// readable status: condition bits also show the live level
	assign sr1_v = {3'h0, l1_ff[4], l1_ff[3:0] | c1};
	assign sr2_v = {l2_ff[7:4], l2_ff[3:0] | c2};
	assign sr3_v = l3_ff | c3;
	assign sr4_v = l4_ff;

	assign info = {|(l4_ff & imr4_ff),
		|(l3_ff & imr3_ff),
		|(l2_ff & imr2_ff),
		|(l1_ff & imr1_ff[4:0])};

	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			o_irq <= 1'b0;
		end else begin
			o_irq <= |info;
		end
	end

	// read decode
	always_comb begin
		nxt_rdata = 8'h00;
		if (!i_rd) begin
			nxt_rdata = 8'h00;
		end else if (i_addr == tae_pkg::ADDR_INFO) begin
			nxt_rdata = {4'h0, info};
		end else if (i_addr == tae_pkg::ADDR_SR1) begin
			nxt_rdata = sr1_v;
		end else if (i_addr == tae_pkg::ADDR_IMR1) begin
			nxt_rdata = imr1_ff;
		end else if (i_addr == tae_pkg::ADDR_SR2) begin
			nxt_rdata = sr2_v;
		end else if (i_addr == tae_pkg::ADDR_IMR2) begin
			nxt_rdata = imr2_ff;
		end else if (i_addr == tae_pkg::ADDR_SR3) begin
			nxt_rdata = sr3_v;
		end else if (i_addr == tae_pkg::ADDR_IMR3) begin
			nxt_rdata = imr3_ff;
		end else if (i_addr == tae_pkg::ADDR_SR4) begin
			nxt_rdata = sr4_v;
		end else if (i_addr == tae_pkg::ADDR_IMR4) begin
			nxt_rdata = imr4_ff;
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			o_rdata <= 8'h00;
		end else begin
			o_rdata <= nxt_rdata;
		end
	end
endmodule

// ### dv/tae_alarm_event_status_asserts.sv
// port checks of the alarm, event and mask block
`timescale 1ns/1ps
module tae_aes_asserts (
	input wire logic              i_sys_clk,
	input wire logic              i_rst,
	input wire logic [7:0]        i_addr,
	input wire logic              i_rd,
	input wire logic [7:0]        o_rdata,
	input wire logic              i_e1_mode,
	input wire logic              i_clock_loss_pin_enable,
	input wire logic              i_tx_clock_in,
	input wire tae_pkg::tae_fr_t  i_framer,
	input wire logic              o_tx_clock_loss,
	input wire logic              o_irq
);
	logic [8:0] tx_idle_ff;
	logic       tx_q_ff;
	// cycles since the transmit clock pin last moved
	always_ff @(posedge i_sys_clk) begin
		tx_q_ff <= i_tx_clock_in;
		if (i_rst || tx_q_ff != i_tx_clock_in)
			tx_idle_ff <= '0;
		else if (tx_idle_ff != 9'h1ff)
			tx_idle_ff <= tx_idle_ff + 9'h001;
	end
	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (i_rst);
	a_rdata_idle: assert property (!$past(i_rd) |-> o_rdata == 8'h00)
		else $error("read data outside read slot");
	a_unmapped_zero: assert property (i_rd && !(i_addr inside {8'h50, 8'h58, [8'h5c:8'h74]})
		|=> o_rdata == 8'h00) else $error("unmapped read not zero");
	a_info_upper: assert property (i_rd && i_addr == 8'h50 |=> o_rdata[7:4] == 4'h0)
		else $error("info upper bits set");
	a_sync_live: assert property (i_framer.sync_lost [*4] ##0 (i_rd && i_addr == 8'h60)
		|=> o_rdata[0]) else $error("sync lost not shown");
	a_yellow_live: assert property ((i_framer.yellow_alarm && !i_e1_mode) [*4]
		##0 (i_rd && i_addr == 8'h60) |=> o_rdata[3]) else $error("yellow not shown");
	a_remote_live: assert property ((i_framer.remote_alarm && i_e1_mode) [*4]
		##0 (i_rd && i_addr == 8'h68) |=> o_rdata[0]) else $error("remote not shown");
	a_pin_gate: assert property (o_tx_clock_loss |-> $past(i_clock_loss_pin_enable))
		else $error("clock loss pin without enable");
	a_pin_early: assert property ($rose(o_tx_clock_loss) |-> tx_idle_ff >= 9'h09e)
		else $error("clock loss pin too early");
	a_pin_late: assert property (i_clock_loss_pin_enable [*3] ##0 tx_idle_ff >= 9'h0e6
		|-> o_tx_clock_loss) else $error("clock loss pin missing");
endmodule

bind tae_alarm_event_status tae_aes_asserts u_chk (.i_sys_clk(i_sys_clk), .i_rst(i_rst),
	.i_addr(i_addr), .i_rd(i_rd), .o_rdata(o_rdata), .i_e1_mode(i_e1_mode),
	.i_clock_loss_pin_enable(i_clock_loss_pin_enable), .i_tx_clock_in(i_tx_clock_in),
	.i_framer(i_framer), .o_tx_clock_loss(o_tx_clock_loss), .o_irq(o_irq));

// ### dv/tae_line_model.sv
// line side model: line clock and alternate-mark receive data
`timescale 1ns/1ps
module tae_line_model (
	input  wire logic i_sys_clk,
	input  wire logic i_run,
	input  wire logic i_zeros,
	output logic      o_clk,
	output logic      o_pos,
	output logic      o_neg,
	output int        o_zcnt
);
	logic [1:0] ph = '0;
	logic       clk_q = 1'b0;
	logic       mark = 1'b0;
	logic [1:0] dat = '0;
	int         zc = 0;
	assign o_clk = clk_q;
	assign {o_pos, o_neg} = dat;
	assign o_zcnt = zc;
	// clock stands still while stopped; new bit on falling edge
	always @(posedge i_sys_clk) begin
		ph <= (ph == 2'h2) ? 2'h0 : ph + 2'h1;
		if (ph == 2'h2 && i_run) begin
			clk_q <= ~clk_q;
			if (clk_q && i_zeros) begin
				dat <= 2'h0;
				zc <= zc + 1;
			end else if (clk_q) begin
				dat <= mark ? 2'h1 : 2'h2;
				mark <= ~mark;
				zc <= 0;
			end
		end
	end
endmodule

// ### dv/testbench.sv
// self-checking bench of the alarm, event and mask block
`timescale 1ns/1ps
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin fails++; \
	$display("Error %s exp %h got %h", n, e, g); end end
module testbench;
	logic clk = 0, rst = 1, wr = 0, rd = 0, e1 = 0, ext = 0, pen = 0, run = 1, zeros = 0;
	logic [7:0] addr = '0, wdata = '0, v;
	// gates the tx clock pin alone, so tx and rx clock loss can be told apart
	logic txoff = 0;
	tae_pkg::tae_fr_t fr = '0;
	tae_pkg::tae_ts16_t ts = '0;
	wire logic [7:0] rdata;
	wire logic txl, irq, lclk, pos, neg;
	int zc, fails = 0, total_checks = 0, seed = 24;
	logic [23:0] q[$];
	logic [23:0] e;
	logic rd_q = 0;
	always #12.5 clk = ~clk;
	tae_alarm_event_status i_dut (.i_sys_clk(clk), .i_rst(rst), .i_addr(addr),
		.i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_e1_mode(e1),
		.i_extended_zero_count_sel(ext), .i_clock_loss_pin_enable(pen),
		.i_rx_pos_data_in(pos), .i_rx_neg_data_in(neg), .i_rx_clock_in(lclk),
		.i_tx_clock_in(lclk && !txoff), .i_framer(fr), .i_ts16(ts),
		.o_tx_clock_loss(txl), .o_irq(irq));
	tae_line_model i_line (.i_sys_clk(clk), .i_run(run), .i_zeros(zeros), .o_clk(lclk),
		.o_pos(pos), .o_neg(neg), .o_zcnt(zc));
	always @(posedge clk) begin
		rd_q <= rd;
		if (rd_q) begin
			e = q.pop_front();
			`CHK("o_rdata", e[7:0], rdata & e[15:8])
		end
	end
	task automatic complete_run;
		if (fails == 0 && total_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task automatic tick(int n);
		repeat (n) @(posedge clk);
	endtask
	task automatic rdr(logic [7:0] a, logic [7:0] x, logic [7:0] m = 8'hff);
		@(posedge clk);
		rd <= 1;
		addr <= a;
		q.push_back({a, m, x & m});
		@(posedge clk);
		rd <= 0;
	endtask
	task automatic wrr(logic [7:0] a, logic [7:0] d);
		@(posedge clk);
		wr <= 1;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		wr <= 0;
	endtask
	// level conditions: raise, read, drop, read twice
	task automatic cond(logic m1, tae_pkg::tae_fr_t b, logic [7:0] a, m, xs, xc);
		int k;
		k = (a - tae_pkg::ADDR_SR1) / 8;
		wrr(a + 8'h04, m);
		e1 <= m1;
		tick(3);
		fr <= b;
		tick(6);
		`CHK("o_irq", |(xs & m), irq)
		rdr(tae_pkg::ADDR_INFO, 8'(|(xs & m)) << k);
		rdr(a, xs);
		fr <= '0;
		tick(6);
		`CHK("o_irq", |(xc & m), irq)
		rdr(a, xc);
		rdr(a, 8'h00);
	endtask
	task automatic pulse(logic m1, tae_pkg::tae_fr_t b, logic [7:0] a, m, x);
		wrr(a + 8'h04, m);
		e1 <= m1;
		tick(3);
		fr <= b;
		tick(1);
		fr <= '0;
		tick(5);
		`CHK("o_irq", |(x & m), irq)
		rdr(a, x);
		rdr(a, 8'h00);
	endtask
	task automatic wt_zc(int n);
		for (int i = 0; i < 20000 && zc < n; i++)
			tick(1);
		if (zc < n) begin
			fails++;
			complete_run();
		end
	endtask
	task automatic zrun(logic m1, logic x, int lim);
		e1 <= m1;
		ext <= x;
		zeros <= 1;
		// one zero short of the limit, then exactly at it
		wt_zc(lim - 1);
		tick(5);
		rdr(tae_pkg::ADDR_SR2, 8'h00, 8'h02);
		wt_zc(lim);
		tick(5);
		rdr(tae_pkg::ADDR_SR2, 8'h02, 8'h02);
		zeros <= 0;
		tick(40);
		rdr(tae_pkg::ADDR_SR2, 8'h20, 8'h22);
	endtask
	task automatic mf(logic [7:0] b0, logic [7:0] b);
		for (int i = 0; i < 16; i++) begin
			@(posedge clk);
			ts <= '{1'b1, i == 0, (i == 0) ? b0 : b};
			@(posedge clk);
			ts <= '{1'b0, 1'b0, 8'($random(seed))};
			tick(4);
		end
	endtask
	initial begin
		tick(3);
		rst <= 0;
		tick(1);
		rdr(tae_pkg::ADDR_INFO, 8'h00);
		rdr(8'h00, 8'h00);
		for (int i = 0; i < 6; i++)
			rdr(tae_pkg::ADDR_SR2 + 8'(4 * i), tae_pkg::REG_RESET);
		for (int i = 0; i < 3; i++) begin
			v = 8'($random(seed));
			wrr(tae_pkg::ADDR_IMR2 + 8'(8 * i), v);
			rdr(tae_pkg::ADDR_IMR2 + 8'(8 * i), v);
			wrr(tae_pkg::ADDR_SR2 + 8'(8 * i), 8'hff);
			rdr(tae_pkg::ADDR_SR2 + 8'(8 * i), 8'h00);
		end
		cond(0, 19'h3c000, tae_pkg::ADDR_SR1, 8'h01, 8'h0f, 8'h0f);
		cond(0, 19'h03800, tae_pkg::ADDR_SR2, 8'h08, 8'h0d, 8'hd0);
		cond(0, 19'h00700, tae_pkg::ADDR_SR3, 8'h20, 8'he0, 8'he0);
		cond(1, 19'h000c0, tae_pkg::ADDR_SR3, 8'h04, 8'h05, 8'h05);
		pulse(1, 19'h0003f, tae_pkg::ADDR_SR4, 8'h1f, 8'h1f);
		pulse(0, 19'h0003f, tae_pkg::ADDR_SR4, 8'h80, 8'h94);
		pulse(0, 19'h40000, tae_pkg::ADDR_SR1, 8'h10, 8'h10);
		pulse(0, 19'h40000, tae_pkg::ADDR_SR1, 8'h00, 8'h10);
		zrun(0, 0, 192);
		zrun(1, 0, 255);
		zrun(1, 1, 2048);
		e1 <= 0;
		run <= 0;
		tick(200);
		rdr(tae_pkg::ADDR_SR3, 8'h00, 8'h18);
		tick(20);
		`CHK("o_tx_clock_loss", 1'b0, txl)
		pen <= 1;
		tick(3);
		`CHK("o_tx_clock_loss", 1'b1, txl)
		rdr(tae_pkg::ADDR_SR3, 8'h18, 8'h18);
		run <= 1;
		tick(10);
		`CHK("o_tx_clock_loss", 1'b0, txl)
		rdr(tae_pkg::ADDR_SR3, 8'h18, 8'h18);
		rdr(tae_pkg::ADDR_SR3, 8'h00, 8'h18);
		txoff <= 1;
		tick(240);
		`CHK("o_tx_clock_loss", 1'b1, txl)
		rdr(tae_pkg::ADDR_SR3, 8'h10, 8'h18);
		txoff <= 0;
		tick(10);
		`CHK("o_tx_clock_loss", 1'b0, txl)
		rdr(tae_pkg::ADDR_SR3, 8'h10, 8'h18);
		e1 <= 1;
		mf(8'h04, 8'hff);
		mf(8'h04, 8'hff);
		rdr(tae_pkg::ADDR_SR3, 8'h02, 8'h02);
		mf(8'h00, 8'h00);
		rdr(tae_pkg::ADDR_SR4, 8'h20, 8'h60);
		mf(8'hff, 8'hff);
		rdr(tae_pkg::ADDR_SR4, 8'h40, 8'h60);
		tick(3);
		complete_run();
	end
endmodule
